// ### design/mic_irq.v
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mic_defs.vh"

module mic_irq #(
  parameter PORT_W = 4,
  parameter TMR_W = 8,
  parameter PC_W = 13
) (
  input wire CLK,
  input wire RST_N,
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire EDGE_IRQ_PIN,
  input wire [PORT_W-1:0] PORT_CHANGE_PINS,
  input wire PORT_READ,
  input wire [TMR_W-1:0] TIMER_ZERO_COUNT,
  input wire CMP_EVENT,
  input wire RETURN_FROM_INTERRUPT_INSTR,
  input wire SLEEP_INSTR,
  output reg IRQ_PENDING,
  output reg VECTOR_LOAD,
  output reg PUSH_RETURN,
  output reg [PC_W-1:0] VECTOR_ADDR,
  output reg FORCE_NOP,
  output reg SLEEPING,
  output reg WAKE
);

  localparam ST_RUN = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_WAKE = 2'd2;

  // interrupt control fields
  reg global_irq_enable_r;
  reg timer_overflow_enable_r;
  reg edge_irq_enable_r;
  reg port_change_enable_r;
  reg timer_overflow_flag_r;
  reg edge_irq_flag_r;
  reg port_change_flag_r;
  reg [7:0] option_r;
  reg cmp_flag_r;
  reg cmp_enable_r;

  // event detection state
  reg edge_pin_q_r;
  reg [PORT_W-1:0] port_latch_r;
  reg [TMR_W-1:0] tmr_prev_r;
  // first cycle after reset only captures levels, so no false event
  reg det_armed_r;

  // sleep and entry sequencing
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg edge_en_at_sleep_r;

  // bus holding registers
  reg aw_hold_r;
  reg w_hold_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg wstrb0_r;

  wire edge_pol = option_r[`MIC_B_EDGE_POL];
  // a level seen in the previous cycle against the current one
  wire edge_rise = EDGE_IRQ_PIN & ~edge_pin_q_r;
  wire edge_fall = ~EDGE_IRQ_PIN & edge_pin_q_r;
  wire edge_event = det_armed_r &
                    (edge_pol ? edge_rise : edge_fall);
  // port latch reloads on read, so a change in that cycle is swallowed
  wire port_event = det_armed_r & ~PORT_READ &
                    (|(PORT_CHANGE_PINS ^ port_latch_r));
  wire tmr_event = (tmr_prev_r == `MIC_TMR_TOP) &&
                   (TIMER_ZERO_COUNT == `MIC_TMR_ZERO);

  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire do_write = aw_hold_r & w_hold_r & ~S_AXI_BVALID;
  wire [11:0] w_idx = {2'b00, awaddr_r[11:2]};
  wire [11:0] r_idx = {2'b00, S_AXI_ARADDR[11:2]};
  wire wr_en = do_write & wstrb0_r;
  wire wr_ictl = wr_en & (w_idx == `MIC_IDX_ICTL);
  wire wr_option = wr_en & (w_idx == `MIC_IDX_OPTION);
  wire wr_pflag = wr_en & (w_idx == `MIC_IDX_PFLAG);
  wire wr_pen = wr_en & (w_idx == `MIC_IDX_PEN);
  wire w_mapped = (w_idx == `MIC_IDX_ICTL) ||
                  (w_idx == `MIC_IDX_OPTION) ||
                  (w_idx == `MIC_IDX_PFLAG) ||
                  (w_idx == `MIC_IDX_PEN);
  wire r_mapped = (r_idx == `MIC_IDX_ICTL) ||
                  (r_idx == `MIC_IDX_OPTION) ||
                  (r_idx == `MIC_IDX_PFLAG) ||
                  (r_idx == `MIC_IDX_PEN);

  // enabled sources, before the global enable
  wire src_active = (edge_irq_flag_r & edge_irq_enable_r) |
                    (timer_overflow_flag_r & timer_overflow_enable_r) |
                    (port_change_flag_r & port_change_enable_r) |
                    (cmp_flag_r & cmp_enable_r);
  // waking uses the edge enable as it stood when sleep began
  wire wake_src = (edge_irq_flag_r & edge_en_at_sleep_r) |
                  (timer_overflow_flag_r & timer_overflow_enable_r) |
                  (port_change_flag_r & port_change_enable_r) |
                  (cmp_flag_r & cmp_enable_r);
  // the registered request is rechecked against the live enable
  wire take = IRQ_PENDING & global_irq_enable_r & ~VECTOR_LOAD &
              (state_r == ST_RUN);

  wire [7:0] ictl_rd = {global_irq_enable_r, 1'b0,
                          timer_overflow_enable_r, edge_irq_enable_r,
                          port_change_enable_r, timer_overflow_flag_r,
                          edge_irq_flag_r, port_change_flag_r};

  reg [7:0] rd_byte;
  always @* begin
    case (r_idx)
      `MIC_IDX_ICTL: rd_byte = ictl_rd;
      `MIC_IDX_OPTION: rd_byte = option_r;
      `MIC_IDX_PFLAG: rd_byte = {1'b0, cmp_flag_r, 6'h00};
      `MIC_IDX_PEN: rd_byte = {1'b0, cmp_enable_r, 6'h00};
      default: rd_byte = 8'h00;
    endcase
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (SLEEP_INSTR) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_src) begin
          state_nxt = ST_WAKE;
        end
      end
      // one cycle for the prefetched instruction before any vector
      ST_WAKE: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      edge_pin_q_r <= 1'b0;
      port_latch_r <= {PORT_W{1'b0}};
      tmr_prev_r <= {TMR_W{1'b0}};
      det_armed_r <= 1'b0;
    end else begin
      edge_pin_q_r <= EDGE_IRQ_PIN;
      tmr_prev_r <= TIMER_ZERO_COUNT;
      det_armed_r <= 1'b1;
      if (PORT_READ || !det_armed_r) begin
        port_latch_r <= PORT_CHANGE_PINS;
      end
    end
  end

  // flags: set beats a software clear in the same cycle
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      edge_irq_flag_r <= 1'b0;
      timer_overflow_flag_r <= 1'b0;
      port_change_flag_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else begin
      edge_irq_flag_r <= (wr_ictl ? wdata_r[`MIC_B_EDGE_FLAG] :
                          edge_irq_flag_r) | edge_event;
      timer_overflow_flag_r <= (wr_ictl ? wdata_r[`MIC_B_TMR_FLAG] :
                                timer_overflow_flag_r) |
                               tmr_event;
      port_change_flag_r <= (wr_ictl ? wdata_r[`MIC_B_PORT_FLAG] :
                             port_change_flag_r) |
                            port_event;
      cmp_flag_r <= (wr_pflag ? wdata_r[`MIC_B_CMP] : cmp_flag_r) |
                    CMP_EVENT;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      global_irq_enable_r <= 1'b0;
      timer_overflow_enable_r <= 1'b0;
      edge_irq_enable_r <= 1'b0;
      port_change_enable_r <= 1'b0;
      option_r <= `MIC_OPTION_RST;
      cmp_enable_r <= 1'b0;
    end else begin
      if (take) begin
        global_irq_enable_r <= 1'b0;
      end else if (RETURN_FROM_INTERRUPT_INSTR) begin
        global_irq_enable_r <= 1'b1;
      end else if (wr_ictl) begin
        global_irq_enable_r <= wdata_r[`MIC_B_GLB_EN];
      end
      if (wr_ictl) begin
        timer_overflow_enable_r <= wdata_r[`MIC_B_TMR_EN];
        edge_irq_enable_r <= wdata_r[`MIC_B_EDGE_EN];
        port_change_enable_r <= wdata_r[`MIC_B_PORT_EN];
      end
      if (wr_option) begin
        option_r <= wdata_r[7:0];
      end
      if (wr_pen) begin
        cmp_enable_r <= wdata_r[`MIC_B_CMP];
      end
    end
  end

  // core handshake; all outputs are flops
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
      edge_en_at_sleep_r <= 1'b0;
      IRQ_PENDING <= 1'b0;
      VECTOR_LOAD <= 1'b0;
      PUSH_RETURN <= 1'b0;
      VECTOR_ADDR <= `MIC_VECTOR;
      FORCE_NOP <= 1'b0;
      SLEEPING <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_RUN && SLEEP_INSTR) begin
        edge_en_at_sleep_r <= edge_irq_enable_r;
      end
      IRQ_PENDING <= global_irq_enable_r & src_active;
      // three cycles: flag, request, vector
      VECTOR_LOAD <= take;
      // only the return address is saved by hardware
      PUSH_RETURN <= take;
      VECTOR_ADDR <= `MIC_VECTOR;
      FORCE_NOP <= IRQ_PENDING & ~global_irq_enable_r &
                   ~VECTOR_LOAD;
      SLEEPING <= (state_nxt == ST_SLEEP);
      WAKE <= (state_r == ST_SLEEP) & wake_src;
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `MIC_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else begin
      S_AXI_AWREADY <= S_AXI_AWVALID & ~S_AXI_AWREADY & ~aw_hold_r &
                       ~S_AXI_BVALID;
      S_AXI_WREADY <= S_AXI_WVALID & ~S_AXI_WREADY & ~w_hold_r &
                      ~S_AXI_BVALID;
      if (aw_hs) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb0_r <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= w_mapped ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `MIC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (ar_hs) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h00_0000, rd_byte};
        S_AXI_RRESP <= r_mapped ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### include/mic_defs.vh
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

`define MIC_AW 12
`define MIC_IDX_ICTL 12'h00b
`define MIC_IDX_OPTION 12'h081
`define MIC_IDX_PFLAG 12'h00c
`define MIC_IDX_PEN 12'h08c

`define MIC_B_GLB_EN 7
`define MIC_B_TMR_EN 5
`define MIC_B_EDGE_EN 4
`define MIC_B_PORT_EN 3
`define MIC_B_TMR_FLAG 2
`define MIC_B_EDGE_FLAG 1
`define MIC_B_PORT_FLAG 0
`define MIC_B_EDGE_POL 6
`define MIC_B_CMP 6

`define MIC_OPTION_RST 8'hff
`define MIC_VECTOR 13'h0004
`define MIC_TMR_TOP 8'hff
`define MIC_TMR_ZERO 8'h00
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

`endif

// ### tb/mic_irq_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mic_irq_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic IRQ_PENDING,
  input wire logic VECTOR_LOAD,
  input wire logic PUSH_RETURN,
  input wire logic [12:0] VECTOR_ADDR,
  input wire logic FORCE_NOP,
  input wire logic SLEEPING,
  input wire logic WAKE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  vec_push_a: assert property (VECTOR_LOAD == PUSH_RETURN)
    else $error("push and vector differ");
  vec_addr_a: assert property (VECTOR_ADDR == 13'h0004)
    else $error("vector address wrong");
  vec_cause_a: assert property (VECTOR_LOAD |-> $past(IRQ_PENDING))
    else $error("vector without request");
  gie_drop_a: assert property (VECTOR_LOAD |=> !IRQ_PENDING && !VECTOR_LOAD)
    else $error("request stays after vector");
  nop_block_a: assert property (FORCE_NOP |-> !VECTOR_LOAD)
    else $error("vector during forced no-op");
  sleep_novec_a: assert property (SLEEPING |-> !VECTOR_LOAD)
    else $error("vector while asleep");
  wake_exit_a: assert property ($fell(SLEEPING) |-> WAKE)
    else $error("left sleep without wake");
  rst_quiet_a: assert property ($rose(RST_N) |-> !IRQ_PENDING [*2])
    else $error("request right after reset");
endmodule
bind mic_irq mic_irq_properties u_props (.CLK, .RST_N, .IRQ_PENDING,
  .VECTOR_LOAD, .PUSH_RETURN, .VECTOR_ADDR, .FORCE_NOP, .SLEEPING, .WAKE);
`default_nettype wire

// ### tb/mic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vector_load,
  input wire logic push_return,
  input wire logic [12:0] vector_addr,
  input wire logic ret_req,
  output logic rfi,
  output logic [12:0] pc,
  output int depth,
  output int n_vec
);
  // return only when something was pushed, as a real core would
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rfi <= 0;
      pc <= 0;
      depth <= 0;
      n_vec <= 0;
    end else begin
      rfi <= ret_req && depth > 0;
      if (vector_load) begin
        pc <= vector_addr;
        n_vec <= n_vec + 1;
      end
      if (push_return) depth <= depth + 1;
      else if (rfi) depth <= depth - 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/mic_irq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mic_irq_tb;
  localparam logic [11:0] INTC = 12'h02c, OPT = 12'h204;
  localparam logic [11:0] PFL = 12'h030, PEN = 12'h230;
  logic CLK = 0, RST_N = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, pin = 0, pread = 0, cmp = 0;
  logic slp = 0, ret_req = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rnd;
  logic [3:0] pins = 0;
  logic [7:0] tmr = 0;
  wire logic awready, wready, bvalid, arready, rvalid, pend, vload, push;
  wire logic fnop, sleeping, wake, rfi;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [12:0] vaddr, pc;
  int depth, n_vec, n_mismatch = 0, n_checks = 0;
  logic [33:0] expq[$];
  integer seed = 32'hb66910a9;
  always #20 CLK = ~CLK;
  mic_irq dut (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .EDGE_IRQ_PIN(pin), .PORT_CHANGE_PINS(pins),
    .PORT_READ(pread), .TIMER_ZERO_COUNT(tmr), .CMP_EVENT(cmp),
    .RETURN_FROM_INTERRUPT_INSTR(rfi), .SLEEP_INSTR(slp),
    .IRQ_PENDING(pend), .VECTOR_LOAD(vload), .PUSH_RETURN(push),
    .VECTOR_ADDR(vaddr), .FORCE_NOP(fnop), .SLEEPING(sleeping), .WAKE(wake));
  mic_core_model core (.clk(CLK), .rst_n(RST_N), .vector_load(vload),
    .push_return(push), .vector_addr(vaddr), .ret_req(ret_req), .rfi(rfi),
    .pc(pc), .depth(depth), .n_vec(n_vec));
  task print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b;
    begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      b = 0;
      while (!b) begin
        @(negedge CLK);
        aw = awready;
        w = wready;
        b = bvalid;
        if (b) chk(bresp, 0);
        @(posedge CLK);
        if (aw) awvalid <= 0;
        if (w) wvalid <= 0;
        if (b) bready <= 0;
      end
      @(posedge CLK);
    end
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    logic ar, r;
    begin
      expq.push_back(e);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      r = 0;
      while (!r) begin
        @(negedge CLK);
        ar = arready;
        r = rvalid;
        @(posedge CLK);
        if (ar) arvalid <= 0;
        if (r) rready <= 0;
      end
      @(posedge CLK);
    end
  endtask
  // the reader queues its note; this process pairs it with the answer
  always @(negedge CLK)
    if (rvalid && rready) chk({rresp, rdata}, expq.pop_front());
  task lat(input int e);
    int n;
    begin
      n = 0;
      while (!vload && n < 20) begin
        @(negedge CLK);
        n++;
      end
      chk(n - 1, e);
      repeat (2) @(posedge CLK);
    end
  endtask
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    tk(4);
    RST_N <= 1;
    tk(1);
    rd(INTC, 34'h00);
    rd(OPT, 34'hff);
    rd(12'h3fc, 34'h2_0000_0000);
    pin <= 1;
    tk(3);
    rd(INTC, 34'h02);
    wr(OPT, 8'hbf);
    wr(INTC, 8'h00);
    rd(INTC, 34'h00);
    pin <= 0;
    tk(3);
    rd(INTC, 34'h02);
    wr(INTC, 8'h00);
    pin <= 1;
    tk(3);
    rd(INTC, 34'h00);
    wr(OPT, 8'hff);
    wr(INTC, 8'h80);
    pin <= 0;
    tk(2);
    pin <= 1;
    tk(4);
    chk(n_vec, 0);
    rd(INTC, 34'h82);
    wr(INTC, 8'h90);
    pin <= 0;
    tk(2);
    pin <= 1;
    lat(3);
    chk(pc, 13'h0004);
    chk(depth, 1);
    rd(INTC, 34'h12);
    ret_req <= 1;
    tk(1);
    ret_req <= 0;
    tk(8);
    chk(n_vec, 2);
    wr(INTC, 8'h10);
    ret_req <= 1;
    tk(1);
    ret_req <= 0;
    tk(6);
    chk(n_vec, 2);
    rd(INTC, 34'h90);
    wr(INTC, 8'ha0);
    tmr <= 8'hfe;
    tk(1);
    tmr <= 8'hff;
    tk(1);
    tmr <= 8'h00;
    tk(6);
    chk(n_vec, 3);
    rd(INTC, 34'h24);
    wr(INTC, 8'h00);
    rnd = $random(seed);
    pins <= pins ^ (rnd[3:0] | 4'h1);
    tk(3);
    rd(INTC, 34'h01);
    pread <= 1;
    tk(1);
    pread <= 0;
    wr(INTC, 8'h00);
    // change on the read cycle is swallowed by the latch reload
    pins <= pins ^ 4'h8;
    pread <= 1;
    tk(1);
    pread <= 0;
    tk(3);
    rd(INTC, 34'h00);
    wr(INTC, 8'h88);
    pins <= pins ^ 4'h2;
    tk(6);
    chk(n_vec, 4);
    pread <= 1;
    tk(1);
    pread <= 0;
    wr(PEN, 8'h40);
    rd(PEN, 34'h40);
    cmp <= 1;
    tk(1);
    cmp <= 0;
    tk(3);
    rd(PFL, 34'h40);
    wr(PFL, 8'h00);
    wr(INTC, 8'h10);
    slp <= 1;
    tk(1);
    slp <= 0;
    tk(2);
    chk(sleeping, 1);
    pin <= 0;
    tk(2);
    pin <= 1;
    tk(4);
    chk(sleeping, 0);
    chk(n_vec, 4);
    RST_N <= 0;
    tk(2);
    RST_N <= 1;
    tk(1);
    rd(INTC, 34'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
